// File: src/mlr_pkg.sv
// shared constants and types for the mono panel refresh controller
package mlr_pkg;
	localparam int PIX_W = 10;
	localparam int LINE_W = 9;
	localparam int ADDR_W = 32;
	localparam int WORD_W = 16;
	localparam int LANES = 4;
	localparam int FIFO_DEPTH = 16;
	localparam logic [LINE_W-1:0] ROWS_4BIT_LAST = 9'h0ef;
	localparam logic [4:0] BURST_SHORT = 5'h08;
	localparam logic [4:0] BURST_LONG = 5'h10;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0002;
	localparam logic [4:0] DENS_FULL = 5'h10;
	localparam logic [4:0] DENS_QUARTER = 5'h04;
	localparam logic [4:0] DENS_5_16 = 5'h05;
	localparam logic [4:0] DENS_HALF = 5'h08;
	localparam logic [4:0] DENS_11_16 = 5'h0b;
	localparam logic [4:0] DENS_3_4 = 5'h0c;

	typedef enum logic [1:0] {
		CUR_PASS = 2'b00,
		CUR_BLACK = 2'b01,
		CUR_INVERT = 2'b10,
		CUR_BAD = 2'b11
	} mlr_cursor_e;

	typedef enum logic [1:0] {
		BUS_1BIT = 2'b00,
		BUS_2BIT = 2'b01,
		BUS_4BIT = 2'b10,
		BUS_NONE = 2'b11
	} mlr_bus_e;

	typedef enum logic [1:0] {
		DMA_IDLE = 2'b00,
		DMA_REQ = 2'b01,
		DMA_XFER = 2'b10
	} mlr_dma_e;
endpackage

// File: src/mlr_fifo.sv
// word fifo between the dma engine and the pixel pipeline
`timescale 1ns/10ps
module mlr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic clear_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [AW:0] level_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign level_o = count;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (clear_i) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count = '0;
		end else begin
			// depth need not be a power of two, so wrap explicitly
			if (push)
				next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
			if (pop)
				next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
			if (push && !pop)
				next_count = (AW+1)'(count + 1'b1);
			else if (pop && !push)
				next_count = (AW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (ce_i) begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && push && !clear_i)
			mem[wr_ptr] <= in_data_i;
	end
endmodule

// File: src/mlr_refresh.sv
// mono panel refresh controller: burst dma, cursor, gray mapping, panel bus
`timescale 1ns/10ps
// Notes on behaviour
// - only single non-split mono panels, at most 1024x512 pixels
// - with the 4-bit bus, at most 240 rows and 1024 columns
// - every frame scan starts at the screen start pointer; size from limits
// - no virtual page height storage; software-only boundary value
// - line and pixel counters give the current pixel position for cursor
// - cursor box from 10-bit x, 9-bit y, 5-bit width and height
// - cursor code 00 passes, 01 forces black, 10 inverts; 11 forbidden
// - blink enable alternates original and cursor pixels; else static cursor
// - gray select 0: one memory bit per pixel, fully on or off
// - gray select 1: two bits per pixel, density over frames, 4 levels
// - panel data bus width selectable as 1, 2 or 4 bits
// - pixel values 00 to 11 pick gray palette entries 0 to 3
// - gray codes give densities 0,1/4,5/16,1/2,11/16,3/4,1,1
// - controller off stops before next line fill; resumes synchronously
// - line buffer need raises bus request; after grant, 8/16 word burst
// - flyby: fetched words go straight into the display pipeline
// - zero wait states give one clock per word
// - dma word access programmable as 1, 2, 3 or 4 clocks
// - burst select clear gives 8 words, set gives 16 words
// - cursor disabled when width or height is zero
module mlr_refresh (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic controller_on_i,
	input wire logic burst_long_i,
	input wire logic [1:0] wait_states_i,
	input wire logic gray_select_i,
	input wire logic [1:0] panel_bus_size_i,
	input wire logic [mlr_pkg::ADDR_W-1:0] screen_start_pointer_i,
	input wire logic [7:0] virtual_page_width_i,
	input wire logic [mlr_pkg::PIX_W-1:0] screen_width_limit_i,
	input wire logic [mlr_pkg::LINE_W-1:0] screen_height_limit_i,
	input wire logic [mlr_pkg::PIX_W-1:0] cursor_x_position_i,
	input wire logic [mlr_pkg::LINE_W-1:0] cursor_y_position_i,
	input wire logic [4:0] cursor_width_i,
	input wire logic [4:0] cursor_height_i,
	input wire logic [1:0] cursor_control_i,
	input wire logic cursor_blink_enable_i,
	input wire logic [6:0] blink_divisor_i,
	input wire logic [11:0] gray_palette_map_i,
	output logic bus_request_o,
	input wire logic bus_grant_i,
	output logic mem_read_o,
	output logic [mlr_pkg::ADDR_W-1:0] mem_addr_o,
	input wire logic [mlr_pkg::WORD_W-1:0] mem_data_i,
	input wire logic panel_pixel_clock_i,
	output logic [mlr_pkg::LANES-1:0] panel_data_o,
	output logic shift_clock_o,
	output logic line_pulse_o,
	output logic first_line_marker_o,
	output logic controller_active_o,
	output logic [mlr_pkg::LINE_W-1:0] line_counter_o,
	output logic [mlr_pkg::PIX_W-1:0] pixel_counter_o
);
	import mlr_pkg::*;

	function automatic logic cursor_hit(input logic [PIX_W-1:0] px,
			input logic [LINE_W-1:0] py, input logic [PIX_W-1:0] cx,
			input logic [LINE_W-1:0] cy, input logic [4:0] cw,
			input logic [4:0] ch);
		logic [PIX_W:0] xe;
		logic [LINE_W:0] ye;
		xe = (PIX_W+1)'(cx) + (PIX_W+1)'(cw);
		ye = (LINE_W+1)'(cy) + (LINE_W+1)'(ch);
		cursor_hit = (cw != 5'h00) && (ch != 5'h00)
			&& (px >= cx) && ((PIX_W+1)'(px) < xe)
			&& (py >= cy) && ((LINE_W+1)'(py) < ye);
	endfunction

	function automatic logic density_on(input logic [2:0] code,
			input logic [3:0] phase);
		logic [4:0] thr;
		case (code)
		3'h0: thr = 5'h00;
		3'h1: thr = DENS_QUARTER;
		3'h2: thr = DENS_5_16;
		3'h3: thr = DENS_HALF;
		3'h4: thr = DENS_11_16;
		3'h5: thr = DENS_3_4;
		default: thr = DENS_FULL;
		endcase
		density_on = ({1'b0, phase} < thr);
	endfunction

	logic active, parked, next_active, next_parked;
	logic pc_s1, pc_s2, pc_s3, pix_rise, pix_fall;
	logic [WORD_W-1:0] sr, next_sr;
	logic [4:0] sr_bits, next_sr_bits, need_bits;
	logic [2:0] ppt;
	logic [PIX_W-1:0] x, next_x;
	logic [LINE_W-1:0] y, next_y, eff_hmax;
	logic [3:0] frame, next_frame;
	logic [6:0] blink_cnt, next_blink_cnt;
	logic blink_on, next_blink_on, cursor_show, line_end;
	logic [LANES-1:0] lane_bit, next_panel_data;
	logic next_sclk, next_lp, next_flm;
	mlr_dma_e dma_state, next_dma_state;
	logic [ADDR_W-1:0] line_addr, next_line_addr, next_word_addr, ssp;
	logic [7:0] word_cnt, next_word_cnt, wpl;
	logic [LINE_W-1:0] dma_line, next_dma_line;
	logic [4:0] burst_cnt, next_burst_cnt, burst_len, free;
	logic [1:0] wait_cnt, next_wait_cnt;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [WORD_W-1:0] fifo_out_data;
	logic [4:0] fifo_level;

	// level from a pin: two flops before anything looks at it
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pc_s1 <= 1'b0;
			pc_s2 <= 1'b0;
			pc_s3 <= 1'b0;
		end else if (ce_i) begin
			pc_s1 <= panel_pixel_clock_i;
			pc_s2 <= pc_s1;
			pc_s3 <= pc_s2;
		end
	end
	assign pix_rise = pc_s2 && !pc_s3;
	assign pix_fall = !pc_s2 && pc_s3;

	// 4-bit bus drivers cannot take more rows than this
	assign eff_hmax = (panel_bus_size_i == BUS_4BIT
		&& screen_height_limit_i > ROWS_4BIT_LAST)
		? ROWS_4BIT_LAST : screen_height_limit_i;
	assign ssp = {screen_start_pointer_i[ADDR_W-1:1], 1'b0};
	// no virtual page height input exists at all
	assign burst_len = burst_long_i ? BURST_LONG : BURST_SHORT;
	assign free = 5'(FIFO_DEPTH) - fifo_level;
	assign wpl = gray_select_i ? 8'((11'(screen_width_limit_i) + 11'h001) >> 3)
		: 8'((11'(screen_width_limit_i) + 11'h001) >> 4);

	always_comb begin
		case (panel_bus_size_i)
		BUS_2BIT: ppt = 3'h2;
		BUS_4BIT: ppt = 3'h4;
		default: ppt = 3'h1;
		endcase
	end
	assign need_bits = gray_select_i ? 5'({ppt, 1'b0}) : 5'(ppt);
	assign line_end = ((PIX_W+1)'(x) + (PIX_W+1)'(ppt))
		> (PIX_W+1)'(screen_width_limit_i);
	assign cursor_show = !cursor_blink_enable_i || blink_on;

	// one lane per panel data bit, first pixel on bit 0
	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			logic [PIX_W-1:0] lx;
			logic [1:0] raw, shown;
			logic [3:0] phase;
			logic hit;
			assign lx = PIX_W'(x + gi);
			assign raw = gray_select_i ? sr[WORD_W-1-2*gi -: 2]
				: {1'b0, sr[WORD_W-1-gi]};
			assign hit = cursor_show && cursor_hit(lx, y, cursor_x_position_i,
				cursor_y_position_i, cursor_width_i, cursor_height_i);
			always_comb begin
				shown = raw;
				if (hit) begin
					case (cursor_control_i)
					CUR_BLACK: shown = gray_select_i ? 2'b11 : 2'b01;
					CUR_INVERT: shown = gray_select_i ? ~raw : {1'b0, ~raw[0]};
					default: shown = raw;
					endcase
				end
			end
			// spread phase over position so whole screen does not flicker
			assign phase = 4'(frame + lx[3:0] + y[3:0]);
			assign lane_bit[gi] = (gi < ppt) && (gray_select_i
				? density_on(gray_palette_map_i[3*shown +: 3], phase)
				: shown[0]);
		end
	endgenerate

	assign fifo_out_ready = active && !parked && (sr_bits == 5'h00);

	always_comb begin
		next_active = active;
		next_parked = parked;
		next_sr = sr;
		next_sr_bits = sr_bits;
		next_x = x;
		next_y = y;
		next_frame = frame;
		next_blink_cnt = blink_cnt;
		next_blink_on = blink_on;
		next_panel_data = panel_data_o;
		next_sclk = pix_fall ? 1'b0 : shift_clock_o;
		next_lp = line_pulse_o;
		next_flm = first_line_marker_o;
		if (!active) begin
			// restart at the frame origin on each switch-on from the inactive state
			next_active = controller_on_i;
			next_parked = 1'b0;
			next_sr_bits = 5'h00;
			next_x = '0;
			next_y = '0;
			next_panel_data = '0;
			next_lp = 1'b0;
			next_flm = 1'b0;
		end else if (parked) begin
			if (controller_on_i)
				next_parked = 1'b0;
			else if (dma_state == DMA_IDLE)
				next_active = 1'b0;
		end else if (sr_bits == 5'h00) begin
			if (fifo_out_valid) begin
				next_sr = fifo_out_data;
				next_sr_bits = WORD_BITS;
			end
		end else if (pix_rise) begin
			next_panel_data = lane_bit;
			next_sclk = 1'b1;
			next_lp = 1'b0;
			next_sr = WORD_W'(sr << need_bits);
			next_sr_bits = 5'(sr_bits - need_bits);
			if (line_end) begin
				next_x = '0;
				next_lp = 1'b1;
				next_flm = (y == '0);
				if (!controller_on_i)
					next_parked = 1'b1;
				if (y >= eff_hmax) begin
					next_y = '0;
					next_frame = 4'(frame + 1'b1);
					if (blink_cnt >= blink_divisor_i) begin
						next_blink_cnt = 7'h00;
						next_blink_on = !blink_on;
					end else begin
						next_blink_cnt = 7'(blink_cnt + 1'b1);
					end
				end else begin
					next_y = LINE_W'(y + 1'b1);
				end
			end else begin
				next_x = PIX_W'(x + ppt);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			active <= 1'b0;
			parked <= 1'b0;
			sr <= '0;
			sr_bits <= 5'h00;
			x <= '0;
			y <= '0;
			frame <= 4'h0;
			blink_cnt <= 7'h00;
			blink_on <= 1'b0;
			panel_data_o <= '0;
			shift_clock_o <= 1'b0;
			line_pulse_o <= 1'b0;
			first_line_marker_o <= 1'b0;
		end else if (ce_i) begin
			active <= next_active;
			parked <= next_parked;
			sr <= next_sr;
			sr_bits <= next_sr_bits;
			x <= next_x;
			y <= next_y;
			frame <= next_frame;
			blink_cnt <= next_blink_cnt;
			blink_on <= next_blink_on;
			panel_data_o <= next_panel_data;
			shift_clock_o <= next_sclk;
			line_pulse_o <= next_lp;
			first_line_marker_o <= next_flm;
		end
	end

	// dma side: the bus is held from request through the last word
	assign bus_request_o = (dma_state != DMA_IDLE);
	assign mem_read_o = (dma_state == DMA_XFER);
	assign fifo_in_valid = (dma_state == DMA_XFER)
		&& (wait_cnt == wait_states_i);

	always_comb begin
		next_dma_state = dma_state;
		next_line_addr = line_addr;
		next_word_addr = mem_addr_o;
		next_word_cnt = word_cnt;
		next_dma_line = dma_line;
		next_burst_cnt = burst_cnt;
		next_wait_cnt = wait_cnt;
		if (!active) begin
			next_dma_state = DMA_IDLE;
			next_line_addr = ssp;
			next_word_addr = ssp;
			next_word_cnt = 8'h00;
			next_dma_line = '0;
		end else begin
			case (dma_state)
			DMA_IDLE: begin
				// a burst only starts when it fits whole, and never while off
				if (controller_on_i && free >= burst_len)
					next_dma_state = DMA_REQ;
			end
			DMA_REQ: begin
				next_burst_cnt = 5'h00;
				next_wait_cnt = 2'h0;
				if (bus_grant_i)
					next_dma_state = DMA_XFER;
			end
			DMA_XFER: begin
				if (wait_cnt != wait_states_i) begin
					next_wait_cnt = 2'(wait_cnt + 1'b1);
				end else if (fifo_in_ready) begin
					next_wait_cnt = 2'h0;
					if (9'(word_cnt) + 9'h001 >= 9'(wpl)) begin
						next_word_cnt = 8'h00;
						if (dma_line >= eff_hmax) begin
							next_dma_line = '0;
							next_line_addr = ssp;
							next_word_addr = ssp;
						end else begin
							next_dma_line = LINE_W'(dma_line + 1'b1);
							next_line_addr = line_addr + ADDR_W'(virtual_page_width_i);
							next_word_addr = line_addr + ADDR_W'(virtual_page_width_i);
						end
					end else begin
						next_word_cnt = 8'(word_cnt + 1'b1);
						next_word_addr = mem_addr_o + WORD_STEP;
					end
					if (burst_cnt == 5'(burst_len - 1'b1))
						next_dma_state = DMA_IDLE;
					else
						next_burst_cnt = 5'(burst_cnt + 1'b1);
				end
			end
			default: next_dma_state = DMA_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			dma_state <= DMA_IDLE;
			line_addr <= '0;
			mem_addr_o <= '0;
			word_cnt <= 8'h00;
			dma_line <= '0;
			burst_cnt <= 5'h00;
			wait_cnt <= 2'h0;
		end else if (ce_i) begin
			dma_state <= next_dma_state;
			line_addr <= next_line_addr;
			mem_addr_o <= next_word_addr;
			word_cnt <= next_word_cnt;
			dma_line <= next_dma_line;
			burst_cnt <= next_burst_cnt;
			wait_cnt <= next_wait_cnt;
		end
	end

	// stale prefetched words are dropped whenever the controller stops
	mlr_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH),
		.AW(4)
	) u_fifo (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.clear_i(!active),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(mem_data_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data),
		.level_o(fifo_level)
	);

	assign controller_active_o = active;
	assign line_counter_o = y;
	assign pixel_counter_o = x;
endmodule

// File: verification/mlr_refresh_chk.sv
// port-level assertion checker for the refresh controller
`timescale 1ns/10ps
module mlr_refresh_chk (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic controller_on_i,
	input wire logic burst_long_i,
	input wire logic [1:0] wait_states_i,
	input wire logic [1:0] panel_bus_size_i,
	input wire logic [mlr_pkg::LINE_W-1:0] screen_height_limit_i,
	input wire logic bus_grant_i,
	input wire logic bus_request_o,
	input wire logic mem_read_o,
	input wire logic [mlr_pkg::LANES-1:0] panel_data_o,
	input wire logic shift_clock_o,
	input wire logic controller_active_o,
	input wire logic [mlr_pkg::LINE_W-1:0] line_counter_o,
	input wire logic [mlr_pkg::ADDR_W-1:0] screen_start_pointer_i,
	input wire logic [mlr_pkg::PIX_W-1:0] screen_width_limit_i,
	input wire logic [mlr_pkg::ADDR_W-1:0] mem_addr_o,
	input wire logic [mlr_pkg::PIX_W-1:0] pixel_counter_o
);
	import mlr_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic [6:0] rd_cnt;
	logic [6:0] next_rd_cnt;
	logic [3:0] idle_lanes;
	always_comb begin
		next_rd_cnt = mem_read_o ? rd_cnt + 7'h01 : 7'h00;
		idle_lanes = (panel_bus_size_i == BUS_2BIT) ? 4'hc : 4'he;
		if (panel_bus_size_i == BUS_4BIT)
			idle_lanes = 4'h0;
	end
	always_ff @(posedge clk_i) begin
		rd_cnt <= nrst_i ? next_rd_cnt : 7'h00;
	end
	a_burst_words:
		assert property ($fell(mem_read_o) |-> rd_cnt ==
			(burst_long_i ? 7'h10 : 7'h08) * ({5'h00, wait_states_i} + 7'h01))
		else $error("burst read length wrong");
	a_read_owned:
		assert property (mem_read_o |-> bus_request_o && bus_grant_i)
		else $error("read without granted bus");
	a_grant_start:
		assert property (bus_request_o && bus_grant_i && !mem_read_o
			|=> mem_read_o)
		else $error("burst did not start after grant");
	a_req_holds:
		assert property (bus_request_o && !mem_read_o |=> bus_request_o)
		else $error("request dropped before burst");
	a_req_drop:
		assert property ($fell(mem_read_o) |-> !bus_request_o)
		else $error("request kept after last word");
	a_off_quiet:
		assert property (!controller_active_o |-> !bus_request_o)
		else $error("request while inactive");
	a_on_start:
		assert property (controller_on_i && !controller_active_o
			|=> controller_active_o)
		else $error("controller did not resume");
	a_lane_idle:
		assert property ($rose(shift_clock_o) |->
			(panel_data_o & idle_lanes) == 4'h0)
		else $error("unused panel lane driven");
	a_rows_4bit:
		assert property (panel_bus_size_i == BUS_4BIT |->
			line_counter_o <= ROWS_4BIT_LAST)
		else $error("too many rows on 4-bit bus");
	a_line_bound:
		assert property (line_counter_o <= screen_height_limit_i)
		else $error("line counter past height limit");
	a_scan_start:
		assert property ($rose(controller_active_o) |->
			mem_addr_o == {screen_start_pointer_i[ADDR_W-1:1], 1'b0})
		else $error("scan did not begin at start pointer");
	a_pixel_bound:
		assert property (pixel_counter_o <= screen_width_limit_i)
		else $error("pixel counter past width limit");
endmodule
bind mlr_refresh mlr_refresh_chk chk (.clk_i(clk_i), .nrst_i(nrst_i),
	.controller_on_i(controller_on_i), .burst_long_i(burst_long_i),
	.wait_states_i(wait_states_i), .panel_bus_size_i(panel_bus_size_i),
	.screen_height_limit_i(screen_height_limit_i),
	.bus_grant_i(bus_grant_i), .bus_request_o(bus_request_o),
	.mem_read_o(mem_read_o), .panel_data_o(panel_data_o),
	.shift_clock_o(shift_clock_o),
	.controller_active_o(controller_active_o),
	.line_counter_o(line_counter_o),
	.screen_start_pointer_i(screen_start_pointer_i),
	.screen_width_limit_i(screen_width_limit_i),
	.mem_addr_o(mem_addr_o), .pixel_counter_o(pixel_counter_o));

// File: verification/mlr_host_model.sv
// host bus master and memory answering the refresh dma
`timescale 1ns/10ps
module mlr_host_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic slow_i,
	input wire logic [mlr_pkg::WORD_W-1:0] fill_i,
	input wire logic bus_request_i,
	input wire logic mem_read_i,
	output logic bus_grant_o,
	output logic [mlr_pkg::WORD_W-1:0] mem_data_o
);
	import mlr_pkg::*;
	logic [2:0] wait_cnt;
	logic [WORD_W-1:0] last;
	// grant after a request, held until it drops
	always @(posedge clk_i) begin
		if (!nrst_i || !bus_request_i) begin
			wait_cnt <= 3'h0;
			bus_grant_o <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 3'h1;
			bus_grant_o <= bus_grant_o || !slow_i || wait_cnt == 3'h4;
		end
	end
	// memory enabled only during dma reads, else a changing value
	always @(posedge clk_i) begin
		last <= (!nrst_i || mem_read_i) ? fill_i : ~last;
	end
	assign mem_data_o = mem_read_i ? fill_i : last;
endmodule

// File: verification/mlr_refresh_tb_top.sv
// self-checking bench for the refresh controller
`timescale 1ns/10ps
module mlr_refresh_tb_top;
	import mlr_pkg::*;
	localparam logic [13:0] CUR_CODES = 14'h212d;
	localparam logic [7:0] CUR_EXP [7] = '{10, 0, 10, 0, 0, 128, 118};
	localparam logic [7:0] GRAY_EXP [8] = '{0, 32, 40, 64, 88, 96, 128, 128};
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic pclk = 1'b0;
	logic on = 1'b0, blong = 1'b0, gsel = 1'b0, blink = 1'b0, slow = 1'b0;
	logic [1:0] ws = 2'h0, bsz = 2'h0, cctl = 2'h0;
	logic [4:0] cw = 5'h05, ch = 5'h02;
	logic [11:0] pal = 12'h000;
	logic [15:0] fill = 16'h0000;
	logic [31:0] ssp = 32'h0000_1000; // page kept in range
	logic [7:0] virtual_page_width = 8'h04;
	logic [9:0] wlim = 10'h01f, cx = 10'h004;
	logic [8:0] hlim = 9'h003, cy = 9'h001;
	logic [6:0] bdiv = 7'h01;
	logic gnt, req, rd, sclk, flm, act, lp;
	logic [9:0] pcnt;
	logic [15:0] mdata;
	logic [3:0] pdata;
	logic [8:0] lcnt;
	int err_total = 0;
	int n_tests = 0;
	always #20 clk_i = ~clk_i;
	initial #37 forever #160 pclk = ~pclk;
	mlr_refresh uut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
		.controller_on_i(on), .burst_long_i(blong), .wait_states_i(ws),
		.gray_select_i(gsel), .panel_bus_size_i(bsz),
		.screen_start_pointer_i(ssp), .virtual_page_width_i(virtual_page_width),
		.screen_width_limit_i(wlim), .screen_height_limit_i(hlim),
		.cursor_x_position_i(cx), .cursor_y_position_i(cy),
		.cursor_width_i(cw), .cursor_height_i(ch), .cursor_control_i(cctl),
		.cursor_blink_enable_i(blink), .blink_divisor_i(bdiv),
		.gray_palette_map_i(pal), .bus_request_o(req), .bus_grant_i(gnt),
		.mem_read_o(rd), .mem_addr_o(), .mem_data_i(mdata),
		.panel_pixel_clock_i(pclk), .panel_data_o(pdata),
		.shift_clock_o(sclk), .line_pulse_o(lp), .first_line_marker_o(flm),
		.controller_active_o(act), .line_counter_o(lcnt),
		.pixel_counter_o(pcnt));
	mlr_host_model host (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow),
		.fill_i(fill), .bus_request_i(req), .mem_read_i(rd),
		.bus_grant_o(gnt), .mem_data_o(mdata));
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// on-pixels from one frame marker rise to the next
	task automatic frame_ons(output logic [7:0] ons);
		logic pf, ps, pl;
		int rises, lines;
		ons = 8'h00;
		pf = 1'b1;
		ps = 1'b1;
		pl = 1'b1;
		rises = 0;
		lines = 0;
		for (int t = 0; t < 6000 && rises < 2; t++) begin
			@(negedge clk_i);
			// count before the marker test: the shift raising the marker
			// ends line 0, so whole lines 1 to 0 of the next frame are seen
			if (rises == 1 && sclk && !ps)
				ons += 8'($countones(pdata));
			if (rises == 1 && lp && !pl)
				lines++;
			if (flm && !pf)
				rises++;
			pf = flm;
			ps = sclk;
			pl = lp;
		end
		chk("frame markers", 8'h02, 8'(rises));
		chk("frame lines", 8'(hlim) + 8'h01, 8'(lines));
	endtask
	// stop mid-frame; it parks at a line end, then returns to frame start
	task automatic stop();
		// the bench has no panel supply to cut first
		on = 1'b0;
		for (int t = 0; t < 4000 && act; t++)
			@(negedge clk_i);
		// counters return to the frame origin one clock after stopping
		@(negedge clk_i);
		chk("stopped active", 8'h00, {7'h00, act});
		chk("stopped line", 8'h00, lcnt[7:0]);
		chk("stopped pixel", 8'h00, pcnt[7:0]);
	endtask
	task automatic go();
		// no panel-off pin or supply here, so nothing to wait on
		on = 1'b1;
		@(negedge clk_i);
		chk("restart active", 8'h01, {7'h00, act});
	endtask
	task automatic test_cursor();
		logic [7:0] n, m;
		for (int i = 0; i < 7; i++) begin
			stop();
			cctl = CUR_CODES[2*i +: 2];
			cw = (i == 4) ? 5'h00 : 5'h05;
			fill = (i > 4) ? 16'hffff : 16'h0000;
			go();
			frame_ons(n);
			chk("cursor pixels", CUR_EXP[i], n);
		end
		stop();
		cctl = CUR_INVERT;
		fill = 16'h0000;
		blink = 1'b1;
		go();
		frame_ons(n);
		frame_ons(m);
		chk("blink pair", 8'd10, n + m);
		chk("blink hidden", 8'h00, (n < m) ? n : m);
		blink = 1'b0;
		$display("test cursor done");
	endtask
	task automatic test_gray();
		logic [7:0] n;
		logic [1:0] k;
		for (int c = 0; c < 8; c++) begin
			stop();
			k = c[1:0];
			gsel = 1'b1;
			virtual_page_width = 8'h08;
			cctl = CUR_PASS;
			bsz = k;
			blong = c[0];
			ws = c[2:1];
			slow = c[1];
			fill = {8{k}};
			pal = 12'hfff;
			pal[3*k +: 3] = c[2:0];
			go();
			frame_ons(n);
			chk("gray pixels", GRAY_EXP[c], n);
		end
		$display("test gray done");
	endtask
	initial begin
		repeat (2) @(negedge clk_i);
		nrst_i = 1'b1;
		test_cursor();
		test_gray();
		conclude();
	end
	initial begin
		#3600000;
		err_total++;
		conclude();
	end
endmodule
